// ### design/aux_cal_pkg.sv
// Constants and carrier types for the auxiliary converter result path
package aux_cal_pkg;
  localparam int          RESULT_W     = 16;
  localparam int          STEP_COUNT   = 16;
  localparam int          STEP_W       = 4;
  localparam logic [7:0]  RESULT_BASE  = 8'h10;
  localparam logic [7:0]  RESULT_LAST  = 8'h1f;
  localparam logic [3:0]  SEL_SHORT    = 4'h9;
  localparam logic [3:0]  SEL_LAST     = 4'h7;
  localparam logic [15:0] TRIM_RESET   = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CODE_MAX     = 16'h7fff;
  localparam logic [15:0] CODE_MIN     = 16'h8000;
  localparam int          GAIN_SHIFT   = 16;

  // One raw conversion arriving from the converter
  typedef struct packed {
    logic              valid;
    logic [STEP_W-1:0] step;
    logic [15:0]       code;
  } raw_sample_t;

  // Trim pair as written by the host
  typedef struct packed {
    logic [15:0] offset;
    logic [15:0] gain;
  } trim_t;
endpackage : aux_cal_pkg

// ### design/aux_cal_result_path.sv
// Offset and gain correction with per-step result storage
// Functional notes
// - Gain trim is a signed 16-bit multiplicative correction.
// - Gain factor equals one plus trim over 2^16.
// - Short code on positive select grounds the converter input.
// - Bias buffer enable routes buffer output onto last input channel.
// - Each step result stored at register address 10h to 1Fh.
// - Stored results are two's complement.
// - Results saturate at 7FFFh and 8000h.
`timescale 1ns/1ns
module aux_cal_result_path
  import aux_cal_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Trim and configuration
  input  wire trim_t       trimIn,
  input  wire logic        biasBufferEnable,
  input  wire logic [3:0]  stepPositiveInputSelect,
  // Raw conversions
  input  wire raw_sample_t rawIn,
  // Register read port
  input  wire logic [7:0]  readAddr,
  input  wire logic        readStrobe,
  // Outputs
  output logic [15:0]      readData,
  output logic             readValid,
  output logic             groundInput,
  output logic             biasToLastInput,
  output logic             resultValid,
  output logic [3:0]       resultStep
);

  // Saturate a wide signed value to 16 bits
  function automatic logic [15:0] sat16(input logic signed [35:0] v);
    if (v > $signed({{20{1'b0}}, CODE_MAX}))
      sat16 = CODE_MAX;
    else if (v < $signed({{20{1'b1}}, CODE_MIN}))
      sat16 = CODE_MIN;
    else
      sat16 = v[15:0];
  endfunction : sat16

  // Address lies in the result window
  function automatic logic inWindow(input logic [7:0] a);
    inWindow = (a >= RESULT_BASE) && (a <= RESULT_LAST);
  endfunction : inWindow

  logic signed [35:0] offsetSum;
  logic signed [35:0] offSat;
  logic signed [35:0] product;
  logic signed [35:0] scaled;
  logic [15:0]        corrected;
  logic [15:0]        resultMem [STEP_COUNT];

  // Offset: raw minus trim, clipped before gain
  always_comb begin
    offsetSum = 36'(signed'(rawIn.code)) - 36'(signed'(trimIn.offset));
    offSat    = 36'(signed'(sat16(offsetSum)));
    // (x * (2^16 + g)) >> 16, g signed
    product   = offSat * (36'sd65536 + 36'(signed'(trimIn.gain)));
    scaled    = product >>> GAIN_SHIFT;
    corrected = sat16(scaled);
  end

  // Per-step result registers
  generate
    for (genvar i = 0; i < STEP_COUNT; i++) begin : g_res
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          resultMem[i] <= RESULT_RESET;
        end else if (rawIn.valid && rawIn.step == 4'(i)) begin
          resultMem[i] <= corrected;
        end
      end
    end
  endgenerate

  // Store indication
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      resultValid <= 1'b0;
      resultStep  <= 4'h0;
    end else begin
      resultValid <= rawIn.valid;
      if (rawIn.valid) begin
        resultStep <= rawIn.step;
      end
    end
  end

  // Register read of the result window, zero elsewhere
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readData  <= 16'h0000;
      readValid <= 1'b0;
    end else begin
      readValid <= readStrobe;
      if (readStrobe && inWindow(readAddr)) begin
        readData <= resultMem[readAddr[3:0]];
      end else if (readStrobe) begin
        readData <= 16'h0000;
      end
    end
  end

  // Multiplexer steering controls
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      groundInput     <= 1'b0;
      biasToLastInput <= 1'b0;
    end else begin
      groundInput     <= (stepPositiveInputSelect == SEL_SHORT);
      biasToLastInput <= biasBufferEnable;
    end
  end

  // Stored value matches corrected sample
  store_value_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    rawIn.valid |=> resultMem[$past(rawIn.step)] == $past(corrected))
    else $error("result not stored");

  // Unity gain, zero offset passes raw code
  unity_pass_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (trimIn == '0) |-> corrected == rawIn.code)
    else $error("unity trim altered code");

  // Half gain at 8000h
  half_gain_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (trimIn.gain == 16'h8000 && trimIn.offset == 16'h0000)
      |-> corrected == 16'(signed'(rawIn.code) >>> 1))
    else $error("half gain wrong");

  // Offset trim of all ones adds one code
  offset_one_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (trimIn.gain == 16'h0000 && trimIn.offset == 16'hffff
      && rawIn.code != CODE_MAX) |-> corrected == rawIn.code + 16'h0001)
    else $error("offset trim wrong");

  // Clipping on both ends
  sat_high_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (scaled > 36'sd32767) |-> corrected == CODE_MAX)
    else $error("no positive clip");

  sat_low_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (scaled < -36'sd32768) |-> corrected == CODE_MIN)
    else $error("no negative clip");

  // Short select grounds input next cycle
  short_ground_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (stepPositiveInputSelect == SEL_SHORT) |=> groundInput)
    else $error("short not applied");

  // Bias routing follows enable
  bias_route_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    1'b1 |=> biasToLastInput == $past(biasBufferEnable))
    else $error("bias routing wrong");

  // Read returns stored word
  read_back_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (readStrobe && inWindow(readAddr) && !rawIn.valid)
      |=> readValid && readData == resultMem[$past(readAddr[3:0])])
    else $error("read data wrong");

  // Store pulse and step follow each sample
  store_flag_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    rawIn.valid |=> resultValid && resultStep == $past(rawIn.step))
    else $error("store pulse wrong");

  // No store pulse without a sample
  store_idle_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    !rawIn.valid |=> !resultValid)
    else $error("spurious store pulse");

  // Read pulse follows strobe by one cycle
  read_pulse_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    1'b1 |=> readValid == $past(readStrobe))
    else $error("read pulse wrong");

  // Reads outside the window return zero
  read_outside_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (readStrobe && !inWindow(readAddr)) |=> readData == 16'h0000)
    else $error("outside read not zero");

  // Read data holds between strobes
  read_hold_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    !readStrobe |=> $stable(readData))
    else $error("read data moved");

  // Other selects release the ground switch
  ground_off_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (stepPositiveInputSelect != SEL_SHORT) |=> !groundInput)
    else $error("ground held wrongly");

  // Offset trim sixteen below zero adds sixteen codes
  offset_sixteen_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    (trimIn.gain == 16'h0000 && trimIn.offset == 16'hfff0
      && $signed(rawIn.code) < 16'sh7ff0)
      |-> corrected == rawIn.code + 16'h0010)
    else $error("offset sixteen wrong");

endmodule : aux_cal_result_path

// ### tb/aux_converter_model.sv
// Converter model that presents raw samples to the result path
`timescale 1ns/1ns
module aux_converter_model
  import aux_cal_pkg::*;
(
  // Request from the bench
  input  wire logic        go,
  input  wire logic [3:0]  step,
  input  wire logic [15:0] code,
  // Sample toward the block
  output raw_sample_t      rawOut
);
  logic [15:0] lastCode = 16'h0000;

  // Remember the last code that was sent
  always @(go or code) begin
    if (go) begin
      lastCode = code;
    end
  end

  // Between samples the code lines show the inverse, never stale data
  assign rawOut = {go, step, go ? code : ~lastCode};
endmodule : aux_converter_model

// ### tb/tb.sv
// Self-checking bench for the result path
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("unexpected %0t got %h want %h", $time, a, b); end end
module tb;
  import aux_cal_pkg::*;
  logic        mclk = 0, rstn = 0, go = 0, rs = 0, bias = 0;
  logic [3:0]  st = 0, sel = 0, ss;
  logic [15:0] cd = 0, rd;
  logic [7:0]  ad = 0;
  logic        rv, gi, bl, sv;
  trim_t       trim = '0; // trims start cleared
  raw_sample_t raw;
  int          num_errors = 0, samples_checked = 0, acc = 0;
  // Offset, gain, raw code, expected stored code
  logic [15:0] tv [10][4] = '{'{16'hffff, 16'h0000, 16'h0000, 16'h0001},
    '{16'hfff0, 16'h0000, 16'h0000, 16'h0010},
    '{16'h0000, 16'h8000, 16'h0100, 16'h0080},
    '{16'h0000, 16'h7fff, 16'h1000, 16'h17ff},
    '{16'h0000, 16'hffff, 16'h7fff, 16'h7ffe},
    '{16'h0000, 16'h7fff, 16'h7fff, 16'h7fff},
    '{16'h0001, 16'h0000, 16'h8000, 16'h8000},
    '{16'hfff0, 16'h8000, 16'h7ff8, 16'h3fff},
    '{16'h0000, 16'h8000, 16'h8000, 16'hc000},
    '{16'h0000, 16'h7fff, 16'h8000, 16'h8000}};

  always #5 mclk = ~mclk;

  aux_converter_model aux_converter_model_i (.go(go), .step(st), .code(cd),
    .rawOut(raw));
  aux_cal_result_path aux_cal_result_path_i (.mclk(mclk), .rstn(rstn),
    .trimIn(trim), .biasBufferEnable(bias), .stepPositiveInputSelect(sel),
    .rawIn(raw), .readAddr(ad), .readStrobe(rs), .readData(rd),
    .readValid(rv), .groundInput(gi), .biasToLastInput(bl),
    .resultValid(sv), .resultStep(ss));

  // Store one raw code for a step and read it back
  task automatic cal(input logic [3:0] s, input logic [15:0] c);
    @(negedge mclk);
    go = 1;
    st = s;
    cd = c;
    @(negedge mclk);
    go = 0;
    `CHK(rv, 1'h0)
    `CHK(sv, 1'h1)
    `CHK(ss, s)
    rs = 1;
    ad = 8'h10 + {4'h0, s};
    @(negedge mclk);
    rs = 0;
    `CHK(rv, 1'h1)
    `CHK(sv, 1'h0)
  endtask : cal

  // Plain register read of one address
  task automatic read_word(input logic [7:0] a);
    @(negedge mclk);
    rs = 1;
    ad = a;
    @(negedge mclk);
    rs = 0;
    `CHK(rv, 1'h1)
  endtask : read_word

  // Summary and verdict
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Hang guard
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end

  // Main sequence
  initial begin
    repeat (2) @(negedge mclk);
    `CHK(sv, 1'h0)
    rstn = 1;
    for (int n = 0; n < 16; n++) begin
      cal(n[3:0], 16'h8123 + 16'(n));
      `CHK(rd, 16'h8123 + 16'(n))
    end
    read_word(8'h20);
    `CHK(rd, 16'h0000)
    $display("test map done");
    for (int n = 0; n < 10; n++) begin
      trim = '{tv[n][0], tv[n][1]};
      cal(4'h5, tv[n][2]);
      `CHK(rd, tv[n][3])
    end
    $display("test trim done");
    // Offset calibration: average shorted readings into the trim
    trim = '0;
    sel = SEL_SHORT; // shorted step run at gain one
    for (int n = 0; n < 4; n++) begin
      cal(4'h9, 16'h0006 + 16'(2 * n));
      `CHK(rd, 16'h0006 + 16'(2 * n))
      acc += int'(signed'(rd));
    end
    trim.offset = 16'(acc / 4);
    cal(4'h9, 16'h0006);
    `CHK(rd, 16'hfffd)
    // Gain calibration: unclipped reference, trim from the ratio
    sel = 4'h0;
    trim = '0;
    cal(4'h2, 16'h6fb6);
    `CHK(rd, 16'h6fb6)
    trim.gain = 16'h199a;
    cal(4'h2, 16'h6fb6);
    `CHK(rd, 16'h7ae1)
    $display("test calibration done");
    for (int k = 0; k < 4; k++) begin
      sel = k[0] ? SEL_SHORT : 4'h8;
      bias = k[1];
      @(negedge mclk);
      `CHK(gi, k[0])
      `CHK(bl, k[1])
    end
    $display("test routing done");
    // Reset in mid-run clears results and steering
    rstn = 0;
    @(negedge mclk);
    `CHK(gi, 1'h0)
    `CHK(bl, 1'h0)
    `CHK(rd, 16'h0000)
    rstn = 1;
    read_word(8'h15);
    `CHK(rd, 16'h0000)
    `CHK(bl, 1'h1)
    $display("test reset done");
    stop_test;
  end
endmodule : tb
